// ===== core/mpws_pkg.sv
// Constants shared by the multi-pulse waveform sequencer files.
package mpws_pkg;
  // ****************************************
  // Register byte offsets on the AXI4-Lite slave
  // ****************************************
  localparam logic [7:0] MPWS_CTRL_OFS = 8'h00;
  localparam logic [7:0] MPWS_PATT_OFS = 8'h04;
  localparam logic [7:0] MPWS_FILT_OFS = 8'h08;
  localparam logic [7:0] MPWS_TCTL_OFS = 8'h0C;
  localparam logic [7:0] MPWS_CMP_OFS = 8'h10;
  localparam logic [7:0] MPWS_CAP_OFS = 8'h14;
  localparam logic [7:0] MPWS_CNT_OFS = 8'h18;
  localparam logic [1:0] MPWS_BUF_PAGE = 2'h1;
  localparam logic [1:0] MPWS_RESP_OK = 2'h0;
  localparam logic [1:0] MPWS_RESP_ERR = 2'h2;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int MPWS_C_SDEN = 3;
  localparam int MPWS_C_SDFEN = 4;
  localparam int MPWS_C_EDGE = 5;
  localparam int MPWS_C_GEN = 7;
  localparam int MPWS_C_TMODE = 8;
  localparam int MPWS_C_PDR = 9;
  localparam int MPWS_C_FLAG = 16;
  localparam int MPWS_C_STOP = 20;
  localparam int MPWS_P_RDA = 8;
  localparam int MPWS_P_BANK = 11;
  localparam int MPWS_F_SW = 2;
  localparam int MPWS_F_SEN = 8;
  localparam int MPWS_F_EXP = 11;
  localparam int MPWS_F_STATE = 16;
  localparam int MPWS_T_PSC = 1;
  localparam int MPWS_T_IE = 4;
  localparam int MPWS_T_FLAG = 5;
  // ****************************************
  // Encodings and reset values
  // ****************************************
  localparam logic [2:0] MPWS_M_BUF0 = 3'h0;
  localparam logic [2:0] MPWS_M_WTIME = 3'h1;
  localparam logic [2:0] MPWS_M_RELOAD = 3'h2;
  localparam logic [2:0] MPWS_M_PDUF_A = 3'h3;
  localparam logic [2:0] MPWS_M_PDUF_B = 3'h7;
  localparam logic [1:0] MPWS_E_RISE = 2'h1;
  localparam logic [1:0] MPWS_E_FALL = 2'h2;
  localparam logic [15:0] MPWS_PATT_RST = 16'h0000;
  localparam logic [15:0] MPWS_CMP_RST = 16'hFFFF;
  localparam logic [15:0] MPWS_CNT_MAX = 16'hFFFF;
  // ****************************************
  // Filter lengths in machine clocks, per width code
  // ****************************************
  localparam logic [5:0] MPWS_FLT_BASE = 6'h04;
  localparam logic [1:0] MPWS_SEN_WCODE = 2'h0;
endpackage

// ===== core/mpws_filter.sv
// Input synchroniser with a programmable noise filter.
`timescale 1ns/1ps
module mpws_filter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic din,
  input wire logic enable,
  input wire logic [1:0] width,
  output logic dout
);
  import mpws_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic out;
    logic [5:0] cnt;
  } mpws_filt_s;

  mpws_filt_s st_q;
  mpws_filt_s st_d;
  logic [5:0] len;

  // A level must stay steady for 4 << width clocks before it is accepted.
  assign len = MPWS_FLT_BASE << width;

  // Only s2 looks at s1, so a metastable s1 never reaches the decision.
  always_comb begin
    st_d = st_q;
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
    if (!enable || st_q.s2 == st_q.out) begin
      st_d.cnt = 6'h00;
      st_d.out = st_q.s2;
    end else if (st_q.cnt + 6'h01 >= len) begin
      st_d.cnt = 6'h00;
      st_d.out = st_q.s2;
    end else begin
      st_d.cnt = st_q.cnt + 6'h01;
    end
  end

  // Synchronous reset; the idle level of the pin is high.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, out: 1'b1, cnt: 6'h00};
    end else begin
      st_q <= st_d;
    end
  end

  assign dout = st_q.out;
endmodule

// ===== core/mpws_top.sv
// Multi-pulse waveform sequencer: pattern transfer, shutdown, timer.
// ****************************************
// ****************************************
`timescale 1ns/1ps
module mpws_top (
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire logic [7:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [7:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire logic OSC_RUN,
  input wire logic SHUTDOWN_INPUT_N,
  input wire logic [2:0] POSITION_SENSOR_INPUT,
  input wire logic PULSE_UNIT_OUT,
  input wire logic RELOAD_UNDERFLOW,
  output logic [5:0] WAVEFORM_OUTPUT,
  output logic SHUTDOWN_STOP_STATE,
  output logic GEN_PIN_OUT,
  output logic UNITS_OWNED,
  output logic IRQ
);
  import mpws_pkg::*;

  typedef struct packed {
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [2:0] method;
    logic sd_en;
    logic sdf_en;
    logic [1:0] edge_sel;
    logic gen_en;
    logic tmode;
    logic [5:0] port_data;
    logic [3:0] flags;
    logic stop;
    logic [15:0] pattern;
    logic [15:0][15:0] bufs;
    logic [1:0] sd_w;
    logic [5:0] sen_w;
    logic [2:0] sen_en;
    logic [2:0] expect_pat;
    logic [2:0] sen_prev;
    logic pulse_prev;
    logic tmr_en;
    logic [2:0] psc_sel;
    logic cc_ie;
    logic cc_irq;
    logic [15:0] cmp;
    logic [15:0] cap;
    logic [15:0] cnt;
    logic [7:0] psc;
    logic armed;
  } mpws_state_s;

  mpws_state_s st_q;
  mpws_state_s st_d;
  logic sd_filt;
  logic [2:0] sen_filt;
  logic wr_go;
  logic [7:0] wa;
  logic sd_act;
  logic wt_evt;
  logic pd_evt;
  logic xfer;
  logic buf0_word;
  logic tick;
  logic match;
  logic [7:0] psc_mask;
  logic [3:0] rd_idx;
  logic [31:0] rd_val;
  logic rd_hit;

  // ****************************************
  // Input filters
  // ****************************************
  // Shutdown filter; its width is taken live, so software keeps it
  // steady while the filter is on.
  mpws_filter u_sd_filt (
    .clk(CLOCK),
    .rst_n(RST_N),
    .din(SHUTDOWN_INPUT_N),
    .enable(st_q.sdf_en),
    .width(st_q.sd_w),
    .dout(sd_filt)
  );

  // Sensor filters share the fixed short width.
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sen
      mpws_filter u_sen_filt (
        .clk(CLOCK),
        .rst_n(RST_N),
        .din(POSITION_SENSOR_INPUT[gi]),
        .enable(st_q.sen_en[gi]),
        .width(MPWS_SEN_WCODE),
        .dout(sen_filt[gi])
      );
    end
  endgenerate

  // ****************************************
  // Event decode
  // ****************************************
  // The peripheral clock is gated in stop, so a low oscillator flag
  // masks the shutdown input entirely.
  assign sd_act = st_q.sd_en && OSC_RUN && !sd_filt;
  // Edge sync honours only the two defined codes.
  assign wt_evt = (st_q.edge_sel == MPWS_E_RISE &&
                   PULSE_UNIT_OUT && !st_q.pulse_prev) ||
                  (st_q.edge_sel == MPWS_E_FALL &&
                   !PULSE_UNIT_OUT && st_q.pulse_prev);
  assign pd_evt = sen_filt != st_q.sen_prev;
  assign wr_go = st_q.aw_ok && st_q.w_ok && !st_q.bvalid;
  assign wa = st_q.aw_addr;
  // Byte writes to buffer zero never start anything.
  assign buf0_word = wr_go && wa == {MPWS_BUF_PAGE, 6'h00} &&
                     st_q.wstrb[1:0] == 2'h3;

  // Transfer source per method; buffer zero path stands apart.
  always_comb begin
    unique case (st_q.method)
      MPWS_M_BUF0: xfer = buf0_word;
      MPWS_M_WTIME: xfer = wt_evt;
      MPWS_M_RELOAD: xfer = RELOAD_UNDERFLOW;
      MPWS_M_PDUF_A, MPWS_M_PDUF_B: xfer = pd_evt || RELOAD_UNDERFLOW;
      default: xfer = pd_evt;
    endcase
  end

  // Prescaler tick: the count advances every 2**psc_sel clocks.
  assign psc_mask = 8'((9'h001 << st_q.psc_sel) - 9'h001);
  assign tick = st_q.tmr_en && ((st_q.psc & psc_mask) == psc_mask);
  assign match = tick && st_q.armed && st_q.cnt == st_q.cmp;

  // ****************************************
  // Read mux
  // ****************************************
  assign rd_idx = ARADDR[5:2];
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    if (ARADDR[7:6] == MPWS_BUF_PAGE) begin
      rd_val = {16'h0000, st_q.bufs[rd_idx]};
    end else begin
      unique case (ARADDR)
        MPWS_CTRL_OFS: rd_val = {11'h000, st_q.stop, st_q.flags,
          1'b0, st_q.port_data, st_q.tmode, st_q.gen_en,
          st_q.edge_sel, st_q.sdf_en, st_q.sd_en, st_q.method};
        MPWS_PATT_OFS: rd_val = {16'h0000, st_q.pattern};
        MPWS_FILT_OFS: rd_val = {13'h0000, sen_filt, 2'h0,
          st_q.expect_pat, st_q.sen_en, st_q.sen_w, st_q.sd_w};
        MPWS_TCTL_OFS: rd_val = {26'h0000000, st_q.cc_irq,
          st_q.cc_ie, st_q.psc_sel, st_q.tmr_en};
        MPWS_CMP_OFS: rd_val = {16'h0000, st_q.cmp};
        MPWS_CAP_OFS: rd_val = {16'h0000, st_q.cap};
        MPWS_CNT_OFS: rd_val = {16'h0000, st_q.cnt};
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  // One write and one read in flight; address and data accepted in
  // either order and the response waits for both.
  always_comb begin
    st_d = st_q;
    st_d.pulse_prev = PULSE_UNIT_OUT;
    st_d.sen_prev = sen_filt;
    st_d.psc = st_q.tmr_en ? st_q.psc + 8'h01 : 8'h00;
    if (AWVALID && AWREADY) begin
      st_d.aw_ok = 1'b1;
      st_d.aw_addr = AWADDR;
    end
    if (WVALID && WREADY) begin
      st_d.w_ok = 1'b1;
      st_d.wdata = WDATA;
      st_d.wstrb = WSTRB;
    end
    if (BVALID && BREADY) begin
      st_d.bvalid = 1'b0;
    end
    if (RVALID && RREADY) begin
      st_d.rvalid = 1'b0;
    end
    if (ARVALID && ARREADY) begin
      st_d.rvalid = 1'b1;
      st_d.rdata = rd_val;
      st_d.rresp = rd_hit ? MPWS_RESP_OK : MPWS_RESP_ERR;
    end
    // Register writes; flags are write-one-to-clear.
    if (wr_go) begin
      st_d.aw_ok = 1'b0;
      st_d.w_ok = 1'b0;
      st_d.bvalid = 1'b1;
      st_d.bresp = MPWS_RESP_OK;
      if (wa[7:6] == MPWS_BUF_PAGE) begin
        if (st_q.wstrb[0]) begin
          st_d.bufs[wa[5:2]][7:0] = st_q.wdata[7:0];
        end
        if (st_q.wstrb[1]) begin
          st_d.bufs[wa[5:2]][15:8] = st_q.wdata[15:8];
        end
      end else begin
        unique case (wa)
          MPWS_CTRL_OFS: begin
            st_d.method = st_q.wdata[2:0];
            st_d.sd_en = st_q.wdata[MPWS_C_SDEN];
            st_d.sdf_en = st_q.wdata[MPWS_C_SDFEN];
            st_d.edge_sel = st_q.wdata[MPWS_C_EDGE +: 2];
            st_d.gen_en = st_q.wdata[MPWS_C_GEN];
            st_d.tmode = st_q.wdata[MPWS_C_TMODE];
            st_d.port_data = st_q.wdata[MPWS_C_PDR +: 6];
            st_d.flags = st_q.flags & ~st_q.wdata[MPWS_C_FLAG +: 4];
          end
          MPWS_PATT_OFS: st_d.pattern = st_q.wdata[15:0];
          MPWS_FILT_OFS: begin
            st_d.sd_w = st_q.wdata[1:0];
            st_d.sen_w = st_q.wdata[MPWS_F_SW +: 6];
            st_d.sen_en = st_q.wdata[MPWS_F_SEN +: 3];
            st_d.expect_pat = st_q.wdata[MPWS_F_EXP +: 3];
          end
          MPWS_TCTL_OFS: begin
            st_d.tmr_en = st_q.wdata[0];
            st_d.psc_sel = st_q.wdata[MPWS_T_PSC +: 3];
            st_d.cc_ie = st_q.wdata[MPWS_T_IE];
            st_d.cc_irq = st_q.cc_irq & ~st_q.wdata[MPWS_T_FLAG];
            // Each restart latches the count for speed measurement.
            if (st_q.wdata[0] && !st_q.tmr_en) begin
              st_d.cap = st_q.cnt;
            end
          end
          MPWS_CMP_OFS: begin
            st_d.cmp = st_q.wdata[15:0];
            st_d.armed = st_q.wdata[15:0] != st_q.cnt;
          end
          MPWS_CAP_OFS, MPWS_CNT_OFS: begin
          end
          default: st_d.bresp = MPWS_RESP_ERR;
        endcase
      end
    end
    // Pattern transfer: buffer zero direct, else bank and address
    // walk on from where the pattern register stands.
    if (xfer) begin
      st_d.flags[1] = 1'b1;
      if (st_q.method == MPWS_M_BUF0) begin
        st_d.pattern = {st_q.pattern[15:8], st_q.wdata[7:0]};
      end else begin
        st_d.pattern[7:0] = st_q.bufs[{st_q.pattern[MPWS_P_BANK],
          st_q.pattern[MPWS_P_RDA +: 3]}][7:0];
        {st_d.pattern[MPWS_P_BANK], st_d.pattern[MPWS_P_RDA +: 3]} =
          {st_q.pattern[MPWS_P_BANK], st_q.pattern[MPWS_P_RDA +: 3]}
          + 4'h1;
      end
    end
    // Stop state one cycle after the filtered low; shutdown flag set
    // wins over a clear in the same cycle.
    st_d.stop = sd_act;
    if (sd_act) begin
      st_d.flags[0] = 1'b1;
    end
    if (pd_evt) begin
      st_d.flags[2] = 1'b1;
    end
    if (pd_evt && sen_filt == st_q.expect_pat) begin
      st_d.flags[3] = 1'b1;
    end
    // Timer: match clears with a flag, overflow wraps silently.
    if (tick) begin
      st_d.cnt = match ? 16'h0000 : st_q.cnt + 16'h0001;
    end
    if ((wt_evt && !st_q.tmode) || (pd_evt && st_q.tmode)) begin
      st_d.cnt = 16'h0000;
    end
    if (st_d.cnt != st_d.cmp) begin
      st_d.armed = 1'b1;
    end
    if (match) begin
      st_d.cc_irq = 1'b1;
    end
  end

  // Synchronous reset of the whole state.
  always_ff @(posedge CLOCK) begin
    if (!RST_N) begin
      st_q <= '0;
      st_q.pattern <= MPWS_PATT_RST;
      st_q.cmp <= MPWS_CMP_RST;
      st_q.armed <= 1'b1;
      st_q.sen_prev <= 3'h7;
      st_q.pulse_prev <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign AWREADY = !st_q.aw_ok && !st_q.bvalid;
  assign WREADY = !st_q.w_ok && !st_q.bvalid;
  assign BVALID = st_q.bvalid;
  assign BRESP = st_q.bresp;
  assign ARREADY = !st_q.rvalid;
  assign RVALID = st_q.rvalid;
  assign RDATA = st_q.rdata;
  assign RRESP = st_q.rresp;
  assign WAVEFORM_OUTPUT = st_q.stop ? st_q.port_data
                                     : st_q.pattern[5:0];
  assign SHUTDOWN_STOP_STATE = st_q.stop;
  // The generator owns the pin and both helper units.
  assign GEN_PIN_OUT = st_q.gen_en && PULSE_UNIT_OUT;
  assign UNITS_OWNED = st_q.gen_en;
  assign IRQ = (|st_q.flags) || (st_q.cc_irq && st_q.cc_ie);

  // ****************************************
  // Assertions
  // ****************************************
  sequence sd_seen;
    st_q.sd_en && OSC_RUN && !sd_filt;
  endsequence
  stop_entry_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    sd_seen |=> st_q.stop && st_q.flags[0])
    else $error("stop state late after shutdown");
  osc_gate_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !OSC_RUN |=> !st_q.stop)
    else $error("shutdown acted while oscillator stopped");
  outs_forced_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st_q.stop |-> WAVEFORM_OUTPUT == st_q.port_data)
    else $error("outputs not forced during shutdown");
  irq_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    (|st_q.flags) |-> IRQ)
    else $error("request dropped while flag set");
  cc_irq_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    match ##1 st_q.cc_ie |-> IRQ && st_q.cc_irq)
    else $error("compare clear request missing");
  byte_buf0_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_go && wa == {MPWS_BUF_PAGE, 6'h00} && st_q.wstrb[1:0] != 2'h3
    && st_q.method == MPWS_M_BUF0 && !RELOAD_UNDERFLOW
    |=> $stable(st_q.pattern[7:0]))
    else $error("byte write started a transfer");
  cmp_skip_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    wr_go && wa == MPWS_CMP_OFS && st_q.wdata[15:0] == st_q.cnt
    && !tick |=> !match)
    else $error("equal compare load matched at once");
  ovf_quiet_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    tick && st_q.cnt == MPWS_CNT_MAX && !match
    |=> st_q.cnt == 16'h0000 && !$rose(st_q.cc_irq))
    else $error("overflow misbehaved");
  gen_pin_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    st_q.gen_en |-> GEN_PIN_OUT == PULSE_UNIT_OUT)
    else $error("generator pin not driven by generator");
endmodule

// ===== testbench/mpws_power_stage.sv
// Behavioural motor power stage with position sensors and a fault line.
`timescale 1ns/1ps
module mpws_power_stage (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] drive,
  input wire logic fault,
  output logic fault_n,
  output logic [2:0] sensor
);
  logic [2:0] lag_q;
  // The fault line idles high and is pulled low while the stage is in trouble.
  assign fault_n = !fault;
  // The rotor answers two clocks after the phases change, so the sensors
  // never move in the same cycle as the outputs that caused them.
  // Sensors rest high like the filters after reset, so no false event.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      lag_q <= 3'h7;
      sensor <= 3'h7;
    end else begin
      lag_q <= ~drive[2:0];
      sensor <= lag_q;
    end
  end
endmodule

// ===== testbench/multi_pulse_waveform_sequencer_test.sv
// Self-checking bench for the multi-pulse waveform sequencer.
`timescale 1ns/1ps
module multi_pulse_waveform_sequencer_test;
  import mpws_pkg::*;
  localparam logic [31:0] FLAGS = 32'hF << MPWS_C_FLAG;
  localparam logic [31:0] SDC = (32'h1 << MPWS_C_SDEN) |
    (32'h2A << MPWS_C_PDR);
  localparam logic [31:0] RISE = 32'(MPWS_E_RISE) << MPWS_C_EDGE;
  localparam logic [31:0] FALL = 32'(MPWS_E_FALL) << MPWS_C_EDGE;
  localparam logic [31:0] TIE = 32'h1 << MPWS_T_IE;
  logic CLOCK = 1'h0;
  logic RST_N = 1'h0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0] WSTRB = 4'h0;
  logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0;
  logic ARVALID = 1'h0, RREADY = 1'h0;
  logic OSC_RUN = 1'h0, PULSE_UNIT_OUT = 1'h0, RELOAD_UNDERFLOW = 1'h0;
  logic fault = 1'h0;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
  logic [1:0] BRESP, RRESP, resp;
  logic [31:0] RDATA, rdat, cval;
  logic SHUTDOWN_INPUT_N, SHUTDOWN_STOP_STATE, GEN_PIN_OUT, UNITS_OWNED, IRQ;
  logic [2:0] POSITION_SENSOR_INPUT;
  logic [5:0] WAVEFORM_OUTPUT;
  int err_total = 0;
  int checked = 0;
  int n;
  int len;

  // A free-running 125 MHz clock.
  always #4 CLOCK = ~CLOCK;

  mpws_top dut (
    .CLOCK(CLOCK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY), .RDATA(RDATA),
    .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY), .OSC_RUN(OSC_RUN),
    .SHUTDOWN_INPUT_N(SHUTDOWN_INPUT_N),
    .POSITION_SENSOR_INPUT(POSITION_SENSOR_INPUT),
    .PULSE_UNIT_OUT(PULSE_UNIT_OUT), .RELOAD_UNDERFLOW(RELOAD_UNDERFLOW),
    .WAVEFORM_OUTPUT(WAVEFORM_OUTPUT),
    .SHUTDOWN_STOP_STATE(SHUTDOWN_STOP_STATE), .GEN_PIN_OUT(GEN_PIN_OUT),
    .UNITS_OWNED(UNITS_OWNED), .IRQ(IRQ)
  );

  mpws_power_stage stage (
    .clk(CLOCK), .rst_n(RST_N), .drive(WAVEFORM_OUTPUT), .fault(fault),
    .fault_n(SHUTDOWN_INPUT_N), .sensor(POSITION_SENSOR_INPUT)
  );

  // ****************************************
  // Bus cycles and comparisons
  // ****************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge CLOCK);
  endtask

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    AWADDR <= a;
    WDATA <= d;
    WSTRB <= s;
    AWVALID <= 1'h1;
    WVALID <= 1'h1;
    BREADY <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (AWVALID && AWREADY) AWVALID <= 1'h0;
      if (WVALID && WREADY) WVALID <= 1'h0;
    end while (!BVALID);
    resp = BRESP;
    BREADY <= 1'h0;
    // A free edge keeps the next call from setting ready in this step.
    @(posedge CLOCK);
  endtask

  task automatic rd(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'h1;
    RREADY <= 1'h1;
    do begin
      @(posedge CLOCK);
      if (ARVALID && ARREADY) ARVALID <= 1'h0;
    end while (!RVALID);
    rdat = RDATA;
    resp = RRESP;
    RREADY <= 1'h0;
    @(posedge CLOCK);
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // The reload timer hands over one single-cycle underflow per period.
  task automatic underflow();
    RELOAD_UNDERFLOW <= 1'h1;
    cyc(1);
    RELOAD_UNDERFLOW <= 1'h0;
    cyc(8);
  endtask

  // Pulls the fault line low and times the stop; the window allows for
  // the two-flop synchroniser, the filter and one or two decision cycles.
  task automatic trip(input int flt);
    n = 0;
    fault <= 1'h1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (!SHUTDOWN_STOP_STATE && n < 80);
    chk_reg(32'(n >= flt + 2 && n <= flt + 7), 32'h1);
  endtask

  task automatic summarize();
    $display("Mismatches %0d, comparisons %0d", err_total, checked);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    cyc(10);
    chk_pin({IRQ, SHUTDOWN_STOP_STATE, WAVEFORM_OUTPUT}, 8'h00);
    RST_N <= 1'h1;
    rd(MPWS_CMP_OFS);
    chk_reg(rdat, {16'h0000, MPWS_CMP_RST});
    chk_reg({30'h0, resp}, {30'h0, MPWS_RESP_OK});
    rd(8'h3C);
    chk_reg({30'h0, resp}, {30'h0, MPWS_RESP_ERR});
    wr(8'h3C, 32'hFFFFFFFF, 4'hF);
    chk_reg({30'h0, resp}, {30'h0, MPWS_RESP_ERR});
    wr(MPWS_CNT_OFS, 32'h1234, 4'hF);
    rd(MPWS_CNT_OFS);
    chk_reg(rdat, 32'h0);
    // Buffer-zero method: byte writes must leave the outputs alone.
    wr(MPWS_CTRL_OFS, FLAGS, 4'hF);
    wr(MPWS_PATT_OFS, 32'h0500, 4'hF);
    wr(8'h40, 32'h2D, 4'h1);
    cyc(8);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h00);
    wr(8'h40, 32'h2D00, 4'h2);
    cyc(8);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h00);
    wr(8'h40, 32'h2D, 4'h3);
    cyc(8);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h2D);
    chk_pin({7'h0, IRQ}, 8'h01);
    rd(MPWS_CTRL_OFS);
    chk_reg({31'h0, rdat[MPWS_C_FLAG + 1]}, 32'h1);
    cyc(20);
    wr(MPWS_CTRL_OFS, FLAGS, 4'hF);
    chk_pin({7'h0, IRQ}, 8'h00);
    // Method change keeps stepping from the held bank and address.
    wr(8'h44, 32'h19, 4'h3);
    wr(8'h48, 32'h21, 4'h3);
    wr(MPWS_CTRL_OFS, FLAGS | MPWS_M_RELOAD, 4'hF);
    wr(MPWS_PATT_OFS, 32'h0100, 4'hF);
    underflow();
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h19);
    cyc(20);
    wr(MPWS_CTRL_OFS, FLAGS | MPWS_M_PDUF_A, 4'hF);
    underflow();
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h21);
    rd(MPWS_PATT_OFS);
    chk_reg({20'h0, rdat[11:0]}, 32'h321);
    // Shutdown is ignored while the oscillator stands still.
    wr(MPWS_CTRL_OFS, FLAGS | SDC, 4'hF);
    fault <= 1'h1;
    cyc(10);
    chk_pin({1'h0, SHUTDOWN_STOP_STATE, WAVEFORM_OUTPUT}, 8'h21);
    fault <= 1'h0;
    OSC_RUN <= 1'h1;
    cyc(10);
    trip(0);
    chk_pin({1'h0, SHUTDOWN_STOP_STATE, WAVEFORM_OUTPUT}, 8'h6A);
    chk_pin({7'h0, IRQ}, 8'h01);
    rd(MPWS_CTRL_OFS);
    chk_reg({30'h0, rdat[MPWS_C_STOP], rdat[MPWS_C_FLAG]}, 32'h3);
    fault <= 1'h0;
    cyc(10);
    chk_pin({1'h0, SHUTDOWN_STOP_STATE, WAVEFORM_OUTPUT}, 8'h21);
    // Every filter width: half-length glitch rejected, long low accepted.
    for (int w = 0; w < 4; w++) begin
      len = 4 << w;
      wr(MPWS_CTRL_OFS, FLAGS | SDC, 4'hF);
      wr(MPWS_FILT_OFS, 32'(w) | (32'(w) << MPWS_F_SW), 4'hF);
      wr(MPWS_CTRL_OFS, SDC | (32'h1 << MPWS_C_SDFEN), 4'hF);
      fault <= 1'h1;
      cyc(len / 2);
      fault <= 1'h0;
      cyc(len + 10);
      chk_pin({7'h0, SHUTDOWN_STOP_STATE}, 8'h00);
      trip(len);
      fault <= 1'h0;
      cyc(len + 10);
    end
    // Generator pin ownership.
    PULSE_UNIT_OUT <= 1'h1;
    wr(MPWS_CTRL_OFS, FLAGS, 4'hF);
    cyc(2);
    chk_pin({6'h0, GEN_PIN_OUT, UNITS_OWNED}, 8'h00);
    wr(MPWS_CTRL_OFS, FLAGS | (32'h1 << MPWS_C_GEN), 4'hF);
    cyc(2);
    chk_pin({6'h0, GEN_PIN_OUT, UNITS_OWNED}, 8'h03);
    PULSE_UNIT_OUT <= 1'h0;
    cyc(2);
    chk_pin({6'h0, GEN_PIN_OUT, UNITS_OWNED}, 8'h01);
    wr(MPWS_CTRL_OFS, FLAGS, 4'hF);
    cyc(2);
    chk_pin({6'h0, GEN_PIN_OUT, UNITS_OWNED}, 8'h00);
    // Write-timing method: each edge change passes through disabled.
    wr(8'h4C, 32'h09, 4'h3);
    wr(8'h50, 32'h11, 4'h3);
    wr(MPWS_CTRL_OFS, FLAGS | MPWS_M_WTIME | RISE, 4'hF);
    PULSE_UNIT_OUT <= 1'h1;
    cyc(4);
    PULSE_UNIT_OUT <= 1'h0;
    cyc(4);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h09);
    wr(MPWS_CTRL_OFS, FLAGS | MPWS_M_WTIME, 4'hF);
    wr(MPWS_CTRL_OFS, FLAGS | MPWS_M_WTIME | FALL, 4'hF);
    PULSE_UNIT_OUT <= 1'h1;
    cyc(4);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h09);
    PULSE_UNIT_OUT <= 1'h0;
    cyc(4);
    chk_pin({2'h0, WAVEFORM_OUTPUT}, 8'h11);
    wr(MPWS_CTRL_OFS, FLAGS, 4'hF);
    // Timer: compare-clear match, held request, skipped equal load.
    wr(MPWS_TCTL_OFS, 32'h0, 4'hF);
    wr(MPWS_CMP_OFS, 32'h30, 4'hF);
    wr(MPWS_TCTL_OFS, 32'h1 | TIE, 4'hF);
    cyc(100);
    chk_pin({7'h0, IRQ}, 8'h01);
    rd(MPWS_TCTL_OFS);
    chk_reg({31'h0, rdat[MPWS_T_FLAG]}, 32'h1);
    rd(MPWS_CNT_OFS);
    chk_reg(32'(rdat[15:0] < 16'h30), 32'h1);
    cyc(5);
    chk_pin({7'h0, IRQ}, 8'h01);
    wr(MPWS_TCTL_OFS, TIE | (32'h1 << MPWS_T_FLAG), 4'hF);
    chk_pin({7'h0, IRQ}, 8'h00);
    rd(MPWS_CNT_OFS);
    cval = {16'h0, rdat[15:0]};
    wr(MPWS_CMP_OFS, cval, 4'hF);
    wr(MPWS_TCTL_OFS, 32'h1 | TIE, 4'hF);
    rd(MPWS_CAP_OFS);
    chk_reg({16'h0, rdat[15:0]}, cval);
    cyc(20);
    rd(MPWS_TCTL_OFS);
    chk_reg({31'h0, rdat[MPWS_T_FLAG]}, 32'h0);
    summarize();
  end

  // Cuts a hang short well after the sequence should have finished.
  initial begin
    cyc(20000);
    err_total++;
    summarize();
  end
endmodule
